// *** design/lrse_pkg.sv ***
package lrse_pkg;

  // Rung geometry and flag pools.
  localparam int LRSE_NUM_IN_POS = 5;
  localparam int LRSE_OUT_POS = 5;
  localparam int LRSE_POS_PER_RUNG = 6;
  localparam int LRSE_NUM_ONS = 16;
  localparam int LRSE_NUM_TMR = 16;
  localparam int LRSE_NUM_CTR = 16;
  localparam int LRSE_NUM_EXT = 64;
  localparam int LRSE_NUM_COIL = 64;
  localparam int LRSE_NUM_RUNGS = 64;

  // Timer resolution and clock rate.
  localparam int LRSE_CLK_PERIOD_NS = 25;
  localparam int LRSE_TIMER_RES_NS = 10000000;
  localparam int LRSE_TIMER_TICK_CYCLES = LRSE_TIMER_RES_NS / LRSE_CLK_PERIOD_NS;

  // Comment storage.
  localparam int LRSE_OPND_CMT_CHARS = 8;
  localparam int LRSE_RUNG_CMT_CHARS = 64;
  localparam int LRSE_NUM_OPERANDS = 256;

  // Operand selector layout: class in [7:6], group in [5:4] for the internal class.
  localparam logic [1:0] LRSE_CLASS_EXT = 2'h0;
  localparam logic [1:0] LRSE_CLASS_COIL = 2'h1;
  localparam logic [1:0] LRSE_CLASS_INT = 2'h2;
  localparam logic [1:0] LRSE_GRP_ONS = 2'h0;
  localparam logic [1:0] LRSE_GRP_TMR = 2'h1;
  localparam logic [1:0] LRSE_GRP_CTR = 2'h2;

  // Mode field bit that takes a preset from a register instead of the literal.
  localparam int LRSE_MODE_SRC_REG_BIT = 3;

  // Reset preset of a timer, the largest value, so an unused timer expires only after 65535 ticks.
  localparam logic [15:0] LRSE_TMR_PRESET_RST = 16'hffff;

  typedef enum logic [3:0] {
    LRSE_OP_SHORT = 4'h0,
    LRSE_OP_NO_CONTACT = 4'h1,
    LRSE_OP_NC_CONTACT = 4'h2,
    LRSE_OP_LOGIC_INVERTER = 4'h3,
    LRSE_OP_ONE_SHOT = 4'h4,
    LRSE_OP_PROCESS_VALUE_COMPARE = 4'h5,
    LRSE_OP_OPEN = 4'h6,
    LRSE_OP_COIL = 4'h8,
    LRSE_OP_LATCH = 4'h9,
    LRSE_OP_UNLATCH = 4'ha,
    LRSE_OP_TIMER = 4'hb,
    LRSE_OP_TRANSITION_COUNTER = 4'hc,
    LRSE_OP_COUNTER_RESET = 4'hd
  } lrse_op_e;

  typedef enum logic [1:0] {
    LRSE_PV_POSITION = 2'b00,
    LRSE_PV_VELOCITY = 2'b01,
    LRSE_PV_TORQUE = 2'b10,
    LRSE_PV_ANALOG = 2'b11
  } lrse_pv_sel_e;

  typedef enum logic [1:0] {
    LRSE_CMP_GT = 2'b00,
    LRSE_CMP_LT = 2'b01,
    LRSE_CMP_WINDOW = 2'b10
  } lrse_cmp_e;

  typedef enum logic [1:0] {
    LRSE_TMR_ON_DELAY = 2'b00,
    LRSE_TMR_OFF_DELAY = 2'b01,
    LRSE_TMR_PULSE = 2'b10,
    LRSE_TMR_INV_PULSE = 2'b11
  } lrse_tmr_mode_e;

  typedef enum logic [1:0] {
    LRSE_ST_IDLE = 2'b00,
    LRSE_ST_INPUT = 2'b01,
    LRSE_ST_OUTPUT = 2'b10
  } lrse_state_e;

  // One rung position: operation, operand, mode bits and a 16-bit literal.
  typedef struct packed {
    logic [3:0] op;
    logic [7:0] sel;
    logic [3:0] mode;
    logic [15:0] value;
  } lrse_elem_s;

  // Actual (feedback) process values.
  typedef struct packed {
    logic signed [31:0] position;
    logic signed [31:0] velocity;
    logic signed [31:0] torque;
    logic signed [31:0] analog;
  } lrse_pv_s;

endpackage : lrse_pkg

// *** design/lrse_elem_eval.sv ***
`timescale 1ns/1ps

// Evaluates one input position of a rung from the state arriving on its left.
module lrse_elem_eval
(
  // Element and its left-side state
  input wire lrse_pkg::lrse_elem_s elem,
  input wire logic left_state,
  // Operand sources
  input wire logic operand_bit,
  input wire logic ons_prev,
  input wire lrse_pkg::lrse_pv_s pv,
  input wire logic signed [31:0] reg_data,
  // Results
  output logic result,
  output logic ons_edge
);
  import lrse_pkg::*;

  logic signed [31:0] pv_val;
  logic signed [31:0] win;
  logic cmp_gt;
  logic cmp_lt;
  logic cmp_win;
  logic cmp_true;
  lrse_op_e op;

  assign op = lrse_op_e'(elem.op);
  assign win = signed'({16'h0000, elem.value});

  // Actual values only; commanded values never reach this block.
  always_comb
  begin
    unique case (lrse_pv_sel_e'(elem.mode[1:0]))
      LRSE_PV_POSITION: pv_val = pv.position;
      LRSE_PV_VELOCITY: pv_val = pv.velocity;
      LRSE_PV_TORQUE: pv_val = pv.torque;
      LRSE_PV_ANALOG: pv_val = pv.analog;
    endcase
  end

  assign cmp_gt = pv_val > reg_data;
  assign cmp_lt = pv_val < reg_data;
  assign cmp_win = (pv_val > (reg_data - win)) && (pv_val < (reg_data + win));
  assign cmp_true = (elem.mode[3:2] == LRSE_CMP_GT) ? cmp_gt :
                    (elem.mode[3:2] == LRSE_CMP_LT) ? cmp_lt :
                    (elem.mode[3:2] == LRSE_CMP_WINDOW) ? cmp_win : 1'b0;

  assign ons_edge = left_state & ~ons_prev;

  always_comb
  begin
    case (op)
      LRSE_OP_SHORT: result = left_state & 1'b1;
      LRSE_OP_NO_CONTACT: result = left_state & operand_bit;
      LRSE_OP_NC_CONTACT: result = left_state & ~operand_bit;
      LRSE_OP_LOGIC_INVERTER: result = ~left_state;
      LRSE_OP_ONE_SHOT: result = ons_edge;
      LRSE_OP_PROCESS_VALUE_COMPARE: result = left_state & cmp_true;
      LRSE_OP_OPEN: result = 1'b0;
      default: result = left_state;
    endcase
  end

endmodule : lrse_elem_eval

// *** design/lrse_scan_engine.sv ***
// Operation
// - Rung has five input positions and one output position receiving rung state.
// - Normally open contact is true while its operand is active.
// - Normally closed contact is true while its operand is inactive.
// - Inverter passes the complement of its left-side state.
// - One-shot is true one full scan on input rise; sixteen flags.
// - Shorted connection passes its left-side state onward unchanged.
// - Compare actual position, velocity, torque or analog against register: greater, less, window.
// - Open element is always false; program must not use it alone.
// - Output coil follows the rung state.
// - Latch coil sets its operand and holds it until unlatched.
// - Unlatch coil clears its operand while the rung is true.
// - Sixteen timers, hundredth-second preset from literal or register.
// - On-delay flag rises after preset with rung true, falls with rung.
// - Off-delay flag rises preset after input falls, clears when input rises.
// - Pulse flag is true for the preset after input rises.
// - Inverted pulse flag is false for the preset after input rises.
// - Sixteen counters count rung rises; target from literal or register.
// - Single-cycle flag sets at target, holds until reset coil zeroes count.
// - Continuous flag true one scan at target, count restarts; reset anytime.
// - Store eight-char operand and 64-char rung comments, readable on upload.
`timescale 1ns/1ps

module lrse_scan_engine
#(
  parameter int NUM_RUNGS = lrse_pkg::LRSE_NUM_RUNGS,
  parameter int TICK_CYCLES = lrse_pkg::LRSE_TIMER_TICK_CYCLES,
  parameter int RUNG_AW = $clog2(NUM_RUNGS),
  parameter int CMT_AW = RUNG_AW + 6
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Program download and upload
  input wire logic prog_we,
  input wire logic [RUNG_AW-1:0] prog_rung,
  input wire logic [2:0] prog_pos,
  input wire lrse_pkg::lrse_elem_s prog_wdata,
  output lrse_pkg::lrse_elem_s prog_rdata,
  input wire logic [RUNG_AW:0] program_length,
  // Comment download and upload
  input wire logic cmt_we,
  input wire logic cmt_rung_sel,
  input wire logic [CMT_AW-1:0] cmt_addr,
  input wire logic [7:0] cmt_wdata,
  output logic [7:0] cmt_rdata,
  // Scan control
  input wire logic scan_tick,
  output logic scan_busy,
  output logic scan_done,
  // Operands
  input wire logic [lrse_pkg::LRSE_NUM_EXT-1:0] ext_flags,
  output logic [lrse_pkg::LRSE_NUM_COIL-1:0] coil_flags,
  output logic [lrse_pkg::LRSE_NUM_ONS-1:0] ons_flags,
  output logic [lrse_pkg::LRSE_NUM_TMR-1:0] timer_flags,
  output logic [lrse_pkg::LRSE_NUM_CTR-1:0] counter_flags,
  // Process values and register read
  input wire lrse_pkg::lrse_pv_s pv,
  output logic [7:0] reg_rd_idx,
  input wire logic signed [31:0] reg_rd_data
);
  import lrse_pkg::*;

  localparam int OPND_CMT_AW = $clog2(LRSE_NUM_OPERANDS * LRSE_OPND_CMT_CHARS);

  // Program and comment storage.
  lrse_elem_s prog_mem [NUM_RUNGS][LRSE_POS_PER_RUNG];
  logic [7:0] rung_cmt_mem [NUM_RUNGS * LRSE_RUNG_CMT_CHARS];
  logic [7:0] opnd_cmt_mem [LRSE_NUM_OPERANDS * LRSE_OPND_CMT_CHARS];

  // Scan sequencer.
  lrse_state_e st_r;
  lrse_state_e st_nxt;
  logic [RUNG_AW:0] rung_r;
  logic [RUNG_AW:0] rung_nxt;
  logic [2:0] pos_r;
  logic [2:0] pos_nxt;
  logic rung_val_r;
  logic rung_val_nxt;
  logic done_r;

  // Flag pools.
  logic [LRSE_NUM_COIL-1:0] coil_r;
  logic [LRSE_NUM_ONS-1:0] ons_flag_r;
  logic [LRSE_NUM_ONS-1:0] ons_prev_r;
  logic [LRSE_NUM_TMR-1:0] tmr_in_r;
  logic [1:0] tmr_mode_r [LRSE_NUM_TMR];
  logic [15:0] tmr_acc_r [LRSE_NUM_TMR];
  logic [15:0] tmr_pre_r [LRSE_NUM_TMR];
  logic [LRSE_NUM_CTR-1:0] ctr_in_r;
  logic [LRSE_NUM_CTR-1:0] ctr_flag_r;
  logic [15:0] ctr_cnt_r [LRSE_NUM_CTR];

  // Hundredth-second timebase.
  logic [31:0] tick_cnt_r;
  logic tick;

  // Current element and its decoding.
  lrse_elem_s cur;
  lrse_op_e cur_op;
  logic [3:0] bank_idx;
  logic [5:0] coil_idx;
  logic operand_bit;
  logic [47:0] int_flags;
  logic eval_result;
  logic ons_edge;
  logic in_step;
  logic out_step;
  logic last_rung;
  logic [15:0] preset;
  logic [RUNG_AW-1:0] rung_idx;

  assign rung_idx = rung_r[RUNG_AW-1:0];
  assign cur = prog_mem[rung_idx][pos_r];
  assign cur_op = lrse_op_e'(cur.op);
  assign bank_idx = cur.sel[3:0];
  assign coil_idx = cur.sel[5:0];
  assign in_step = (st_r == LRSE_ST_INPUT);
  assign out_step = (st_r == LRSE_ST_OUTPUT);
  assign last_rung = (rung_r + 1'b1) >= program_length;
  assign int_flags = {counter_flags, timer_flags, ons_flag_r};

  // Operand bit: physical and status inputs, coil flags, or one-shot/timer/counter flags.
  assign operand_bit = (cur.sel[7:6] == LRSE_CLASS_EXT) ? ext_flags[cur.sel[5:0]] :
                       (cur.sel[7:6] == LRSE_CLASS_COIL) ? coil_r[cur.sel[5:0]] :
                       (cur.sel[7:6] == LRSE_CLASS_INT && cur.sel[5:4] != 2'h3) ?
                       int_flags[{cur.sel[5:4], cur.sel[3:0]}] : 1'b0;

  // Register index: compare reference, or preset/target register of a timer or counter.
  assign reg_rd_idx = (cur_op == LRSE_OP_PROCESS_VALUE_COMPARE) ? cur.sel : cur.value[7:0];
  assign preset = cur.mode[LRSE_MODE_SRC_REG_BIT] ? reg_rd_data[15:0] : cur.value;

  lrse_elem_eval u_elem_eval
  (
    .elem(cur),
    .left_state(rung_val_r),
    .operand_bit(operand_bit),
    .ons_prev(ons_prev_r[bank_idx]),
    .pv(pv),
    .reg_data(reg_rd_data),
    .result(eval_result),
    .ons_edge(ons_edge)
  );

  // Five input steps then one output step per rung, rungs in program order.
  always_comb
  begin
    st_nxt = st_r;
    rung_nxt = rung_r;
    pos_nxt = pos_r;
    rung_val_nxt = rung_val_r;
    unique case (st_r)
      LRSE_ST_IDLE:
      begin
        if (scan_tick && program_length != '0)
        begin
          st_nxt = LRSE_ST_INPUT;
          rung_nxt = '0;
          pos_nxt = '0;
          rung_val_nxt = 1'b1;
        end
      end
      LRSE_ST_INPUT:
      begin
        rung_val_nxt = eval_result;
        pos_nxt = pos_r + 3'h1;
        if (pos_r == 3'(LRSE_NUM_IN_POS - 1))
        begin
          st_nxt = LRSE_ST_OUTPUT;
        end
      end
      LRSE_ST_OUTPUT:
      begin
        pos_nxt = '0;
        rung_val_nxt = 1'b1;
        rung_nxt = rung_r + 1'b1;
        if (last_rung)
        begin
          st_nxt = LRSE_ST_IDLE;
        end
        else
        begin
          st_nxt = LRSE_ST_INPUT;
        end
      end
      default:
      begin
        st_nxt = LRSE_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_r <= LRSE_ST_IDLE;
      rung_r <= '0;
      pos_r <= '0;
      rung_val_r <= 1'b1;
      done_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      rung_r <= rung_nxt;
      pos_r <= pos_nxt;
      rung_val_r <= rung_val_nxt;
      done_r <= out_step && last_rung;
    end
  end

  // Program and comment memories; upload reads are registered.
  always_ff @(posedge ref_clk)
  begin
    if (prog_we)
    begin
      prog_mem[prog_rung][prog_pos] <= prog_wdata;
    end
    if (cmt_we && cmt_rung_sel)
    begin
      rung_cmt_mem[cmt_addr] <= cmt_wdata;
    end
    if (cmt_we && !cmt_rung_sel)
    begin
      opnd_cmt_mem[cmt_addr[OPND_CMT_AW-1:0]] <= cmt_wdata;
    end
    prog_rdata <= prog_mem[prog_rung][prog_pos];
    cmt_rdata <= cmt_rung_sel ? rung_cmt_mem[cmt_addr] : opnd_cmt_mem[cmt_addr[OPND_CMT_AW-1:0]];
  end

  // Coils write immediately, so later rungs in the same scan see them.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      coil_r <= '0;
    end
    else if (out_step)
    begin
      if (cur_op == LRSE_OP_COIL)
      begin
        coil_r[coil_idx] <= rung_val_r;
      end
      else if (cur_op == LRSE_OP_LATCH && rung_val_r)
      begin
        coil_r[coil_idx] <= 1'b1;
      end
      else if (cur_op == LRSE_OP_UNLATCH && rung_val_r)
      begin
        coil_r[coil_idx] <= 1'b0;
      end
    end
  end

  // One-shot flag holds from its rung in this scan to the same rung in the next.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ons_flag_r <= '0;
      ons_prev_r <= '0;
    end
    else if (in_step && cur_op == LRSE_OP_ONE_SHOT)
    begin
      ons_flag_r[bank_idx] <= ons_edge;
      ons_prev_r[bank_idx] <= rung_val_r;
    end
  end

  // Timebase in hundredths of a second.
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  always_ff @(posedge ref_clk)
  begin
    if (rst || tick)
    begin
      tick_cnt_r <= '0;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < LRSE_NUM_TMR; gi++)
    begin : g_tmr
      logic hit;
      logic expired;
      assign hit = out_step && cur_op == LRSE_OP_TIMER && bank_idx == 4'(gi);
      assign expired = tmr_acc_r[gi] >= tmr_pre_r[gi];
      // Elapsed time restarts at every change of the timer input.
      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          tmr_in_r[gi] <= 1'b0;
          tmr_mode_r[gi] <= LRSE_TMR_ON_DELAY;
          tmr_acc_r[gi] <= '0;
          tmr_pre_r[gi] <= LRSE_TMR_PRESET_RST;
        end
        else if (hit && rung_val_r != tmr_in_r[gi])
        begin
          tmr_in_r[gi] <= rung_val_r;
          tmr_mode_r[gi] <= cur.mode[1:0];
          tmr_acc_r[gi] <= '0;
          tmr_pre_r[gi] <= preset;
        end
        else if (tick && !expired)
        begin
          tmr_acc_r[gi] <= tmr_acc_r[gi] + 16'h1;
        end
      end
      always_comb
      begin
        unique case (lrse_tmr_mode_e'(tmr_mode_r[gi]))
          LRSE_TMR_ON_DELAY: timer_flags[gi] = tmr_in_r[gi] & expired;
          LRSE_TMR_OFF_DELAY: timer_flags[gi] = ~tmr_in_r[gi] & expired;
          LRSE_TMR_PULSE: timer_flags[gi] = tmr_in_r[gi] & ~expired;
          LRSE_TMR_INV_PULSE: timer_flags[gi] = ~(tmr_in_r[gi] & ~expired);
        endcase
      end
    end

    for (gi = 0; gi < LRSE_NUM_CTR; gi++)
    begin : g_ctr
      logic hit;
      logic clr;
      logic rise;
      logic [15:0] cnt_inc;
      assign hit = out_step && cur_op == LRSE_OP_TRANSITION_COUNTER && bank_idx == 4'(gi);
      assign clr = out_step && cur_op == LRSE_OP_COUNTER_RESET && bank_idx == 4'(gi) && rung_val_r;
      assign rise = rung_val_r & ~ctr_in_r[gi];
      assign cnt_inc = ctr_cnt_r[gi] + 16'h1;
      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          ctr_in_r[gi] <= 1'b0;
          ctr_flag_r[gi] <= 1'b0;
          ctr_cnt_r[gi] <= '0;
        end
        else if (clr)
        begin
          ctr_cnt_r[gi] <= '0;
          ctr_flag_r[gi] <= 1'b0;
        end
        else if (hit)
        begin
          ctr_in_r[gi] <= rung_val_r;
          if (cur.mode[0])
          begin
            // Continuous: one-scan flag, then count restarts from zero.
            ctr_flag_r[gi] <= rise && cnt_inc >= preset;
            if (rise)
            begin
              ctr_cnt_r[gi] <= (cnt_inc >= preset) ? 16'h0 : cnt_inc;
            end
          end
          else
          begin
            // Single cycle: stops at target and holds the flag.
            if (rise && ctr_cnt_r[gi] < preset)
            begin
              ctr_cnt_r[gi] <= cnt_inc;
            end
            ctr_flag_r[gi] <= ((rise && ctr_cnt_r[gi] < preset) ? cnt_inc : ctr_cnt_r[gi]) >= preset;
          end
        end
      end
    end
  endgenerate

  assign coil_flags = coil_r;
  assign ons_flags = ons_flag_r;
  assign counter_flags = ctr_flag_r;
  assign scan_busy = (st_r != LRSE_ST_IDLE);
  assign scan_done = done_r;

endmodule : lrse_scan_engine

// *** verif/lrse_scan_checker.sv ***
`timescale 1ns/1ps

module lrse_scan_checker
#(
  parameter int RUNG_AW = 6
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Scan control
  input wire logic [RUNG_AW:0] program_length,
  input wire logic scan_tick,
  input wire logic scan_busy,
  input wire logic scan_done,
  // Flags
  input wire logic [63:0] coil_flags,
  input wire logic [15:0] ons_flags,
  input wire logic [15:0] counter_flags
);
  logic [15:0] busy_cnt_r;
  logic [15:0] busy_cnt_nxt;
  logic [15:0] scan_cyc;

  // Counts busy cycles of the current scan; a rung takes six cycles.
  assign busy_cnt_nxt = scan_busy ? busy_cnt_r + 16'h1 : 16'h0;
  assign scan_cyc = 16'(program_length) * 16'h6;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      busy_cnt_r <= 16'h0;
    end
    else
    begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_scan_start;
    !scan_busy && scan_tick && program_length != '0 |=> scan_busy;
  endproperty
  a_scan_start: assert property (p_scan_start) else $error("scan not started");

  property p_empty_scan;
    !scan_busy && scan_tick && program_length == '0 |=> !scan_busy ##1 !scan_busy;
  endproperty
  a_empty_scan: assert property (p_empty_scan) else $error("empty program scanned");

  property p_scan_len;
    scan_done |-> busy_cnt_r == scan_cyc;
  endproperty
  a_scan_len: assert property (p_scan_len) else $error("scan length wrong");

  property p_done_pulse;
    scan_done |=> !scan_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

  property p_done_end;
    scan_done |-> $fell(scan_busy);
  endproperty
  a_done_end: assert property (p_done_end) else $error("done not at end of scan");

  // Flags may also fall on the edge after a one-cycle reset.
  property p_coil_win;
    $changed(coil_flags) |-> $past(scan_busy) || $past(rst);
  endproperty
  a_coil_win: assert property (p_coil_win) else $error("coil changed outside scan");

  property p_ons_win;
    $changed(ons_flags) |-> $past(scan_busy) || $past(rst);
  endproperty
  a_ons_win: assert property (p_ons_win) else $error("one-shot changed outside scan");

  property p_ctr_win;
    $changed(counter_flags) |-> $past(scan_busy) || $past(rst);
  endproperty
  a_ctr_win: assert property (p_ctr_win) else $error("counter changed outside scan");
endmodule : lrse_scan_checker

bind lrse_scan_engine lrse_scan_checker #(.RUNG_AW(RUNG_AW)) i_lrse_scan_checker (
  .ref_clk(ref_clk), .rst(rst), .program_length(program_length), .scan_tick(scan_tick),
  .scan_busy(scan_busy), .scan_done(scan_done), .coil_flags(coil_flags),
  .ons_flags(ons_flags), .counter_flags(counter_flags)
);

// *** verif/lrse_io_model.sv ***
`timescale 1ns/1ps

module lrse_io_model
#(
  parameter logic signed [31:0] REG_VAL = 32'sh64
)
(
  // Register read
  input wire logic [7:0] reg_rd_idx,
  output logic signed [31:0] reg_rd_data,
  // Feedback
  input wire logic signed [31:0] pos_val,
  output lrse_pkg::lrse_pv_s pv
);
  import lrse_pkg::*;
  // Register 0 holds the reference, register 1 its negative, any other register its own index.
  assign reg_rd_data = (reg_rd_idx == 8'h00) ? REG_VAL :
                       (reg_rd_idx == 8'h01) ? -REG_VAL : 32'(reg_rd_idx);
  // Each actual value differs so that a wrong selector changes the outcome.
  assign pv = '{position: pos_val, velocity: pos_val + 32'sh5, torque: -pos_val, analog: pos_val <<< 1};
endmodule : lrse_io_model

// *** verif/lrse_scan_engine_tb_top.sv ***
`timescale 1ns/1ps

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; $display("BAD t=%0t got %h exp %h", $time, a, e); end end

module lrse_scan_engine_tb_top;
  import lrse_pkg::*;
  logic ref_clk;
  logic rst;
  logic prog_we;
  logic [5:0] prog_rung;
  logic [2:0] prog_pos;
  lrse_elem_s prog_wdata;
  lrse_elem_s prog_rdata;
  logic [6:0] program_length;
  logic cmt_we;
  logic cmt_rung_sel;
  logic [11:0] cmt_addr;
  logic [7:0] cmt_wdata;
  logic [7:0] cmt_rdata;
  logic scan_tick;
  logic scan_busy;
  logic scan_done;
  logic [63:0] ext_flags;
  logic [63:0] coil_flags;
  logic [15:0] ons_flags;
  logic [15:0] timer_flags;
  logic [15:0] counter_flags;
  lrse_pv_s pv;
  logic [7:0] reg_rd_idx;
  logic signed [31:0] reg_rd_data;
  logic signed [31:0] pos_val;
  int error_cnt = 0;
  int checked = 0;
  logic signed [31:0] pvs [4] = '{32'sh28, 32'sh64, 32'sh69, 32'shc8};
  // Timer flag after rise, after preset, after fall, after preset.
  logic [3:0] tmr_exp [4] = '{4'b0100, 4'b0001, 4'b1000, 4'b0111};

  lrse_scan_engine #(.TICK_CYCLES(4)) i_lrse_scan_engine (
    .ref_clk(ref_clk), .rst(rst), .prog_we(prog_we), .prog_rung(prog_rung), .prog_pos(prog_pos),
    .prog_wdata(prog_wdata), .prog_rdata(prog_rdata), .program_length(program_length),
    .cmt_we(cmt_we), .cmt_rung_sel(cmt_rung_sel), .cmt_addr(cmt_addr), .cmt_wdata(cmt_wdata),
    .cmt_rdata(cmt_rdata), .scan_tick(scan_tick), .scan_busy(scan_busy), .scan_done(scan_done),
    .ext_flags(ext_flags), .coil_flags(coil_flags), .ons_flags(ons_flags), .timer_flags(timer_flags),
    .counter_flags(counter_flags), .pv(pv), .reg_rd_idx(reg_rd_idx), .reg_rd_data(reg_rd_data)
  );

  lrse_io_model i_lrse_io_model (
    .reg_rd_idx(reg_rd_idx), .reg_rd_data(reg_rd_data), .pos_val(pos_val), .pv(pv)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic put(input int r, input int p, input lrse_op_e op, input logic [7:0] sel,
                     input logic [3:0] md, input logic [15:0] val);
    prog_rung = 6'(r);
    prog_pos = 3'(p);
    prog_wdata = {op, sel, md, val};
    prog_we = 1'b1;
    @(negedge ref_clk);
    prog_we = 1'b0;
    @(negedge ref_clk);
  endtask : put

  task automatic cmt_put(input logic sel, input logic [11:0] a, input logic [7:0] d);
    cmt_rung_sel = sel;
    cmt_addr = a;
    cmt_wdata = d;
    cmt_we = 1'b1;
    @(negedge ref_clk);
    cmt_we = 1'b0;
    @(negedge ref_clk);
  endtask : cmt_put

  // Starts one scan and waits, bounded, for its completion pulse.
  task automatic scan();
    int n;
    n = 0;
    scan_tick = 1'b1;
    @(negedge ref_clk);
    scan_tick = 1'b0;
    while (scan_done !== 1'b1 && n < 500)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 500)
    begin
      error_cnt++;
      results();
    end
    @(negedge ref_clk);
  endtask : scan

  initial
  begin
    rst = 1'b1;
    prog_we = 1'b0;
    prog_rung = 6'h0;
    prog_pos = 3'h0;
    prog_wdata = '0;
    program_length = 7'h0;
    cmt_we = 1'b0;
    cmt_rung_sel = 1'b0;
    cmt_addr = 12'h0;
    cmt_wdata = 8'h0;
    scan_tick = 1'b0;
    ext_flags = 64'h0;
    pos_val = 32'sh0;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    scan_tick = 1'b1;
    @(negedge ref_clk);
    scan_tick = 1'b0;
    @(negedge ref_clk);
    `CHK(scan_busy, 1'b0)
    for (int r = 0; r < 13; r++)
    begin
      for (int p = 0; p < 6; p++)
      begin
        put(r, p, LRSE_OP_SHORT, 8'h00, 4'h0, 16'h0);
      end
    end
    put(0, 0, LRSE_OP_NO_CONTACT, 8'h00, 4'h0, 16'h0);
    put(0, 1, LRSE_OP_NC_CONTACT, 8'h01, 4'h0, 16'h0);
    put(0, 5, LRSE_OP_COIL, 8'h00, 4'h0, 16'h0);
    put(1, 0, LRSE_OP_NO_CONTACT, 8'h00, 4'h0, 16'h0);
    put(1, 1, LRSE_OP_LOGIC_INVERTER, 8'h00, 4'h0, 16'h0);
    put(1, 5, LRSE_OP_COIL, 8'h01, 4'h0, 16'h0);
    put(2, 0, LRSE_OP_NO_CONTACT, 8'h40, 4'h0, 16'h0);
    put(2, 1, LRSE_OP_ONE_SHOT, 8'h80, 4'h0, 16'h0);
    put(2, 5, LRSE_OP_COIL, 8'h02, 4'h0, 16'h0);
    put(3, 0, LRSE_OP_NO_CONTACT, 8'h02, 4'h0, 16'h0);
    put(3, 5, LRSE_OP_LATCH, 8'h03, 4'h0, 16'h0);
    put(4, 0, LRSE_OP_NO_CONTACT, 8'h03, 4'h0, 16'h0);
    put(4, 5, LRSE_OP_UNLATCH, 8'h03, 4'h0, 16'h0);
    put(5, 0, LRSE_OP_PROCESS_VALUE_COMPARE, 8'h00, 4'h0, 16'h0);
    put(5, 5, LRSE_OP_COIL, 8'h05, 4'h0, 16'h0);
    put(6, 0, LRSE_OP_PROCESS_VALUE_COMPARE, 8'h00, 4'h9, 16'ha);
    put(6, 5, LRSE_OP_COIL, 8'h06, 4'h0, 16'h0);
    put(7, 0, LRSE_OP_PROCESS_VALUE_COMPARE, 8'h00, 4'h7, 16'h0);
    put(7, 5, LRSE_OP_COIL, 8'h07, 4'h0, 16'h0);
    put(8, 0, LRSE_OP_NO_CONTACT, 8'h00, 4'h0, 16'h0);
    put(8, 2, LRSE_OP_OPEN, 8'h00, 4'h0, 16'h0);
    put(8, 5, LRSE_OP_COIL, 8'h08, 4'h0, 16'h0);
    put(9, 0, LRSE_OP_NO_CONTACT, 8'h04, 4'h0, 16'h0);
    put(10, 0, LRSE_OP_NO_CONTACT, 8'h05, 4'h0, 16'h0);
    put(11, 0, LRSE_OP_NO_CONTACT, 8'h06, 4'h0, 16'h0);
    put(12, 0, LRSE_OP_PROCESS_VALUE_COMPARE, 8'h01, 4'h6, 16'h0);
    put(12, 5, LRSE_OP_COIL, 8'h09, 4'h0, 16'h0);
    put(11, 5, LRSE_OP_COUNTER_RESET, 8'ha0, 4'h0, 16'h0);
    `CHK(prog_rdata, {LRSE_OP_COUNTER_RESET, 8'ha0, 4'h0, 16'h0})
    cmt_put(1'b1, {6'h2, 6'h3f}, 8'h5a);
    `CHK(cmt_rdata, 8'h5a)
    cmt_put(1'b0, {1'b0, 8'hc8, 3'h7}, 8'ha5);
    `CHK(cmt_rdata, 8'ha5)
    cmt_rung_sel = 1'b1;
    cmt_addr = {6'h2, 6'h3f};
    @(negedge ref_clk);
    `CHK(cmt_rdata, 8'h5a)
    program_length = 7'hd;
    for (int i = 0; i < 4; i++)
    begin
      ext_flags[1:0] = 2'(i);
      scan();
      `CHK(coil_flags[0], ext_flags[0] & ~ext_flags[1])
      `CHK(coil_flags[1], ~ext_flags[0])
      `CHK(coil_flags[8], 1'b0)
    end
    for (int i = 0; i < 4; i++)
    begin
      ext_flags[1:0] = 2'(8'h75 >> (2 * i));
      scan();
      `CHK(coil_flags[2], 1'((4'h9 >> i) & 4'h1))
      `CHK(ons_flags[0], 1'((4'h9 >> i) & 4'h1))
    end
    for (int i = 0; i < 4; i++)
    begin
      ext_flags[3:2] = 2'(8'h21 >> (2 * i));
      scan();
      `CHK(coil_flags[3], 1'((4'h3 >> i) & 4'h1))
    end
    for (int i = 0; i < 4; i++)
    begin
      pos_val = pvs[i];
      scan();
      `CHK(coil_flags[5], 1'(pvs[i] > 32'sh64))
      `CHK(coil_flags[6], 1'(pvs[i] > 32'sh55 && pvs[i] < 32'sh69))
      `CHK(coil_flags[7], 1'(pvs[i] < 32'sh32))
      `CHK(coil_flags[9], 1'(pvs[i] > 32'sh64))
    end
    for (int m = 0; m < 4; m++)
    begin
      put(9, 5, LRSE_OP_TIMER, 8'h90, 4'(m) | {m[0], 3'h0}, {7'h0, m[0], 8'h14});
      ext_flags[4] = 1'b0;
      scan();
      repeat (200) @(negedge ref_clk);
      ext_flags[4] = 1'b1;
      scan();
      `CHK(timer_flags[0], tmr_exp[m][3])
      repeat (200) @(negedge ref_clk);
      `CHK(timer_flags[0], tmr_exp[m][2])
      ext_flags[4] = 1'b0;
      scan();
      `CHK(timer_flags[0], tmr_exp[m][1])
      repeat (200) @(negedge ref_clk);
      `CHK(timer_flags[0], tmr_exp[m][0])
    end
    for (int c = 0; c < 2; c++)
    begin
      put(10, 5, LRSE_OP_TRANSITION_COUNTER, 8'ha0, 4'(9 * c), 16'(3 + 512 * c));
      for (int i = 1; i < 5; i++)
      begin
        ext_flags[5] = 1'b1;
        scan();
        `CHK(counter_flags[0], 1'((c == 0) ? (i >= 3) : (i == 3)))
        ext_flags[5] = 1'b0;
        scan();
        `CHK(counter_flags[0], 1'(c == 0 && i >= 3))
      end
      ext_flags[6] = 1'b1;
      scan();
      `CHK(counter_flags[0], 1'b0)
      ext_flags[6] = 1'b0;
      scan();
    end
    results();
  end
endmodule : lrse_scan_engine_tb_top
